// ===== core/prm_pkg.sv
/*
  prm_pkg: constants and types for the pin remap matrix.
  assumes one system clock and a synchronous active-low reset.
*/
package prm_pkg;
  localparam int PRM_FIELD_W = 6;
  localparam int PRM_NUM_PINS = 32;
  localparam int PRM_NUM_IN = 42;
  localparam int PRM_NUM_OUT_FN = 32;
  localparam int PRM_IN_REGS = PRM_NUM_IN / 2;
  localparam int PRM_OUT_REGS = PRM_NUM_PINS / 2;
  localparam int PRM_IDX_W = 5;
  localparam int PRM_LO_POS = 0;
  localparam int PRM_HI_POS = 8;
  localparam logic [5:0] PRM_NULL_CODE = 6'h00;
  localparam logic [5:0] PRM_IN_RESET = 6'h3F;
  localparam logic [5:0] PRM_OUT_RESET = 6'h00;
  localparam logic [5:0] PRM_SPI1_CLK_CODE = 6'h08;
  localparam logic [15:0] PRM_REG_MASK = 16'h3F3F;
  typedef enum logic [1:0] {
    PRM_WR_NONE = 2'b00,
    PRM_WR_IN = 2'b01,
    PRM_WR_OUT = 2'b10,
    PRM_WR_ALT = 2'b11
  } prm_wr_type;
endpackage

// ===== core/prm_sync.sv
/*
  prm_sync: three-stage input synchroniser per bit, change taken when
  stages two and three agree.
  assumes inputs come from pins outside the clock domain.
*/
`timescale 1ns/1ns
module prm_sync
  import prm_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, q_r;
  logic [WIDTH-1:0] q_nxt;
  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        q_nxt[i] = s3_r[i];
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end
  assign sync_out = q_r;
endmodule

// ===== core/prm_matrix.sv
/*
  prm_matrix: pin remap matrix with input map and output map fields,
  pin ownership priority and the alternate spi clock pin.
  assumes control writes come from same-clock logic as plain ports;
  pin levels and analog/fixed enables arrive from the pad ring.
*/
`timescale 1ns/1ns
module prm_matrix
  import prm_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic [4:0] wr_index,
  input wire logic [15:0] wr_data,
  input wire logic [4:0] rd_index,
  output logic [15:0] in_map_rd,
  output logic [15:0] out_map_rd,
  output logic alt_spi_clock_map_bit,
  input wire logic [PRM_NUM_PINS-1:0] pin_in,
  input wire logic [PRM_NUM_PINS-1:0] pin_analog_en,
  input wire logic [PRM_NUM_PINS-1:0] port_out,
  input wire logic [PRM_NUM_PINS-1:0] port_direction_setting,
  input wire logic [PRM_NUM_PINS-1:0] parallel_master_port_out,
  input wire logic [PRM_NUM_PINS-1:0] parallel_master_port_oe,
  input wire logic [PRM_NUM_PINS-1:0] fixed_out,
  input wire logic [PRM_NUM_PINS-1:0] fixed_oe,
  input wire logic [PRM_NUM_OUT_FN-1:0] periph_out,
  output logic [PRM_NUM_PINS-1:0] pin_out,
  output logic [PRM_NUM_PINS-1:0] pin_oe,
  output logic [PRM_NUM_PINS-1:0] remap_owned,
  output logic [PRM_NUM_IN-1:0] periph_in,
  output logic fixed_spi_clock_pin_out,
  output logic fixed_spi_clock_pin_oe
);
  // one clock domain: every check below shares the clock, and all but chk_reset_unrouted share the reset
  default clocking prm_cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////
  logic [5:0] in_map_r [PRM_NUM_IN];
  logic [5:0] in_map_nxt [PRM_NUM_IN];
  logic [5:0] out_map_r [PRM_NUM_PINS];
  logic [5:0] out_map_nxt [PRM_NUM_PINS];
  logic alt_r, alt_nxt;
  logic [PRM_NUM_PINS-1:0] pin_sync;
  prm_wr_type wsel;
  assign wsel = prm_wr_type'(wr_sel);

  prm_sync #(.WIDTH(PRM_NUM_PINS)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  //////////////////////////////////////////////////////////////////////
  // separate sets, each in-range input or output map write sets both fields of one register; an alt write sets only alt_r
  always_comb begin
    alt_nxt = alt_r;
    for (int i = 0; i < PRM_NUM_IN; i++) begin
      in_map_nxt[i] = in_map_r[i];
    end
    for (int p = 0; p < PRM_NUM_PINS; p++) begin
      out_map_nxt[p] = out_map_r[p];
    end
    if (wr_en) begin
      case (wsel)
        PRM_WR_IN: begin
          if (int'(wr_index) < PRM_IN_REGS) begin
            in_map_nxt[2*wr_index] = wr_data[PRM_LO_POS +: PRM_FIELD_W];
            in_map_nxt[2*wr_index+1] = wr_data[PRM_HI_POS +: PRM_FIELD_W];
          end
        end
        PRM_WR_OUT: begin
          if (int'(wr_index) < PRM_OUT_REGS) begin
            out_map_nxt[2*wr_index] = wr_data[PRM_LO_POS +: PRM_FIELD_W];
            out_map_nxt[2*wr_index+1] = wr_data[PRM_HI_POS +: PRM_FIELD_W];
          end
        end
        PRM_WR_ALT: alt_nxt = wr_data[0];
        default: alt_nxt = alt_r;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      alt_r <= 1'b0;
      for (int i = 0; i < PRM_NUM_IN; i++) begin
        in_map_r[i] <= PRM_IN_RESET;
      end
      for (int p = 0; p < PRM_NUM_PINS; p++) begin
        out_map_r[p] <= PRM_OUT_RESET;
      end
    end else begin
      alt_r <= alt_nxt;
      for (int i = 0; i < PRM_NUM_IN; i++) begin
        in_map_r[i] <= in_map_nxt[i];
      end
      for (int p = 0; p < PRM_NUM_PINS; p++) begin
        out_map_r[p] <= out_map_nxt[p];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // only digital functions appear in these vectors
  logic [PRM_NUM_PINS-1:0] pin_out_nxt, pin_oe_nxt, owned_nxt;
  logic [PRM_NUM_IN-1:0] periph_in_nxt;
  logic [15:0] in_rd_nxt, out_rd_nxt;

  genvar g;
  generate
    for (g = 0; g < PRM_NUM_PINS; g++) begin : g_pin
      logic [5:0] code;
      logic sel_valid;
      assign code = out_map_r[g];
      // null code and unknown codes stay disconnected
      assign sel_valid = (code != PRM_NULL_CODE)
        && (int'(code) < PRM_NUM_OUT_FN)
        && !(alt_r && code == PRM_SPI1_CLK_CODE);
      // fixed > remap > parallel port > port
      always_comb begin
        owned_nxt[g] = 1'b0;
        if (fixed_oe[g]) begin
          pin_out_nxt[g] = fixed_out[g];
          pin_oe_nxt[g] = 1'b1;
        end else if (sel_valid) begin
          pin_out_nxt[g] = periph_out[code[4:0]];
          pin_oe_nxt[g] = 1'b1;
          owned_nxt[g] = 1'b1;
        end else if (parallel_master_port_oe[g]) begin
          pin_out_nxt[g] = parallel_master_port_out[g];
          pin_oe_nxt[g] = 1'b1;
        end else begin
          pin_out_nxt[g] = port_out[g];
          pin_oe_nxt[g] = !port_direction_setting[g];
        end
      end
    end
    for (g = 0; g < PRM_NUM_IN; g++) begin : g_in
      logic [5:0] src;
      assign src = in_map_r[g];
      // analog pins and out-of-range numbers read zero
      always_comb begin
        if (int'(src) < PRM_NUM_PINS) begin
          periph_in_nxt[g] = pin_sync[src[4:0]]
            && !pin_analog_en[src[4:0]];
        end else begin
          periph_in_nxt[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    in_rd_nxt = 16'h0000;
    out_rd_nxt = 16'h0000;
    if (int'(rd_index) < PRM_IN_REGS) begin
      in_rd_nxt[PRM_LO_POS +: PRM_FIELD_W] = in_map_r[2*rd_index];
      in_rd_nxt[PRM_HI_POS +: PRM_FIELD_W] = in_map_r[2*rd_index+1];
    end
    if (int'(rd_index) < PRM_OUT_REGS) begin
      out_rd_nxt[PRM_LO_POS +: PRM_FIELD_W] = out_map_r[2*rd_index];
      out_rd_nxt[PRM_HI_POS +: PRM_FIELD_W] = out_map_r[2*rd_index+1];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registered outputs: one cycle after the map registers settle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pin_out <= '0;
      pin_oe <= '0;
      remap_owned <= '0;
      periph_in <= '0;
      in_map_rd <= 16'h0000;
      out_map_rd <= 16'h0000;
      alt_spi_clock_map_bit <= 1'b0;
      fixed_spi_clock_pin_out <= 1'b0;
      fixed_spi_clock_pin_oe <= 1'b0;
    end else begin
      pin_out <= pin_out_nxt;
      pin_oe <= pin_oe_nxt;
      remap_owned <= owned_nxt;
      periph_in <= periph_in_nxt;
      in_map_rd <= in_rd_nxt;
      out_map_rd <= out_rd_nxt;
      alt_spi_clock_map_bit <= alt_r;
      fixed_spi_clock_pin_out <= alt_r & periph_out[PRM_SPI1_CLK_CODE[4:0]];
      fixed_spi_clock_pin_oe <= alt_r;
    end
  end

  //////////////////////////////////////////////////////////////////////
  chk_null_code_off: assert property (
    (out_map_r[0] == PRM_NULL_CODE && !fixed_oe[0])
    |=> !remap_owned[0]
  ) else $error("null code still routes pin 0");
  chk_big_code_off: assert property (
    (int'(out_map_r[0]) >= PRM_NUM_OUT_FN)
    |=> !remap_owned[0]
  ) else $error("unknown code routes pin 0");

  chk_fixed_wins_pin: assert property (
    fixed_oe[1]
    |=> (pin_oe[1] && pin_out[1] == $past(fixed_out[1]))
  ) else $error("fixed output lost priority");
  chk_fixed_not_owned: assert property (
    fixed_oe[1]
    |=> !remap_owned[1]
  ) else $error("matrix owns a fixed pin");

  chk_remap_over_pmp: assert property (
    (!fixed_oe[2] && out_map_r[2] == 6'h01)
    |=> (pin_oe[2] && pin_out[2] == $past(periph_out[1]))
  ) else $error("remap output did not win over port");
  chk_pmp_when_free: assert property (
    (!fixed_oe[5] && out_map_r[5] == PRM_NULL_CODE
      && parallel_master_port_oe[5])
    |=> (pin_oe[5] && pin_out[5] == $past(parallel_master_port_out[5]))
  ) else $error("parallel port lost a free pin");
  chk_owned_drives: assert property (
    (remap_owned & ~pin_oe) == '0
  ) else $error("owned pin not driven");

  chk_port_dir_kept: assert property (
    (!fixed_oe[3] && out_map_r[3] == PRM_NULL_CODE
      && !parallel_master_port_oe[3])
    |=> pin_oe[3] == !$past(port_direction_setting[3])
  ) else $error("port direction not kept");
  chk_port_out_kept: assert property (
    (!fixed_oe[3] && out_map_r[3] == PRM_NULL_CODE
      && !parallel_master_port_oe[3])
    |=> pin_out[3] == $past(port_out[3])
  ) else $error("port output level not kept");

  chk_analog_blocks_in: assert property (
    (int'(in_map_r[0]) < PRM_NUM_PINS && pin_analog_en[in_map_r[0][4:0]])
    |=> !periph_in[0]
  ) else $error("input passed analog pin");
  chk_in_path_digital: assert property (
    (int'(in_map_r[0]) < PRM_NUM_PINS && !pin_analog_en[in_map_r[0][4:0]])
    |=> periph_in[0] == $past(pin_sync[in_map_r[0][4:0]])
  ) else $error("input not taken from selected pin");
  chk_in_no_pin: assert property (
    (int'(in_map_r[0]) >= PRM_NUM_PINS)
    |=> !periph_in[0]
  ) else $error("unselected input not zero");

  chk_in_field_write: assert property (
    (wr_en && wsel == PRM_WR_IN && wr_index == 5'h00)
    |=> (in_map_r[1] == $past(wr_data[13:8])
      && in_map_r[0] == $past(wr_data[5:0]))
  ) else $error("input field write not applied");
  chk_out_field_write: assert property (
    (wr_en && wsel == PRM_WR_OUT && wr_index == 5'h00)
    |=> (out_map_r[1] == $past(wr_data[13:8])
      && out_map_r[0] == $past(wr_data[5:0]))
  ) else $error("output field write not applied");
  chk_out_keeps_in: assert property (
    (wr_en && wsel == PRM_WR_OUT)
    |=> in_map_r[0] == $past(in_map_r[0])
  ) else $error("output write disturbed input map");
  chk_in_keeps_out: assert property (
    (wr_en && wsel == PRM_WR_IN)
    |=> out_map_r[0] == $past(out_map_r[0])
  ) else $error("input write disturbed output map");
  chk_bad_in_index: assert property (
    (wr_en && wsel == PRM_WR_IN && int'(wr_index) >= PRM_IN_REGS)
    |=> in_map_r[PRM_NUM_IN-1] == $past(in_map_r[PRM_NUM_IN-1])
  ) else $error("input write past range applied");
  chk_bad_out_index: assert property (
    (wr_en && wsel == PRM_WR_OUT && int'(wr_index) >= PRM_OUT_REGS)
    |=> out_map_r[PRM_NUM_PINS-1] == $past(out_map_r[PRM_NUM_PINS-1])
  ) else $error("output write past range applied");
  chk_alt_kept: assert property (
    !(wr_en && wsel == PRM_WR_ALT)
    |=> alt_r == $past(alt_r)
  ) else $error("alternate bit moved without write");
  chk_in_readback: assert property (
    (rd_index == 5'h00)
    |=> in_map_rd == {2'b00, $past(in_map_r[1]), 2'b00, $past(in_map_r[0])}
  ) else $error("input map readback wrong");
  chk_out_readback: assert property (
    (rd_index == 5'h00)
    |=> out_map_rd == {2'b00, $past(out_map_r[1]), 2'b00, $past(out_map_r[0])}
  ) else $error("output map readback wrong");

  chk_alt_spi_pin: assert property (
    alt_r
    |=> (fixed_spi_clock_pin_oe
      && fixed_spi_clock_pin_out
        == $past(periph_out[PRM_SPI1_CLK_CODE[4:0]]))
  ) else $error("spi clock not on fixed pin");
  chk_alt_off_pin: assert property (
    !alt_r
    |=> (!fixed_spi_clock_pin_oe && !fixed_spi_clock_pin_out)
  ) else $error("fixed spi pin active while bit clear");
  chk_alt_code_off: assert property (
    (alt_r && out_map_r[8] == PRM_SPI1_CLK_CODE)
    |=> !remap_owned[8]
  ) else $error("spi clock routed through matrix too");
  chk_alt_bit_copy: assert property (
    1'b1 |=> alt_spi_clock_map_bit == $past(alt_r)
  ) else $error("alternate bit copy wrong");

  chk_reset_unrouted: assert property (disable iff (1'b0)
    !rstn
    |=> (remap_owned == '0 && periph_in == '0)
  ) else $error("routing present after reset");

  cov_remap_pin: cover property (
    remap_owned[0]);
  cov_alt_on: cover property (
    fixed_spi_clock_pin_oe);
  cov_in_path: cover property (
    periph_in[0]);
  cov_alt_blocks: cover property (
    alt_r && out_map_r[8] == PRM_SPI1_CLK_CODE);
  cov_analog_in: cover property (
    int'(in_map_r[0]) < PRM_NUM_PINS && pin_analog_en[in_map_r[0][4:0]]);
endmodule

// ===== verif/prm_far_model.sv
/*
  prm_far_model: peripheral outputs and pad levels beside the matrix.
  assumes the bench pulses new_pat to ask for a fresh pattern.
*/
`timescale 1ns/1ns
module prm_far_model (
  input wire logic clock,
  input wire logic new_pat,
  output logic [31:0] periph_out,
  output logic [31:0] pin_in
);
  ////////////////////////////////////////////////////////////////
  initial begin
    periph_out = 32'h0;
    pin_in = 32'h0;
  end
  // digital levels only
  // held between requests: the bench needs settled values to compare
  always @(posedge clock) begin
    if (new_pat) begin
      periph_out <= $urandom;
      pin_in <= $urandom;
    end
  end
endmodule

// ===== verif/testbench.sv
/*
  testbench: routes outputs and inputs, compares with a queue-free model.
  assumes prm_matrix with registered outputs and a 4-flop pin sync (3 stages plus an output flop).
*/
`timescale 1ns/1ns
module testbench import prm_pkg::*;;
  logic clock = 0, rstn = 0, wr_en = 0, new_pat = 0;
  logic [1:0] wr_sel = 0;
  logic [4:0] wr_index = 0, rd_index = 0;
  logic [15:0] wr_data = 0, in_rd, out_rd;
  logic alt_bit, fs_out, fs_oe;
  logic [31:0] analog = 0, port_out = 0, dir = '1, pm_out = 0, pm_oe = 0;
  logic [31:0] fx_out = 0, fx_oe = 0, p_out, pin_in, pin_out, pin_oe, own;
  logic [41:0] p_in;
  int failures = 0, checked = 0, cycles = 0, alt = 0;
  int out_f[32], in_f[42];
  ////////////////////////////////////////////////////////////////
  prm_matrix dut (.clock(clock), .rstn(rstn), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_index(wr_index), .wr_data(wr_data),
    .rd_index(rd_index), .in_map_rd(in_rd), .out_map_rd(out_rd),
    .alt_spi_clock_map_bit(alt_bit), .pin_in(pin_in),
    .pin_analog_en(analog), .port_out(port_out),
    .port_direction_setting(dir), .parallel_master_port_out(pm_out),
    .parallel_master_port_oe(pm_oe), .fixed_out(fx_out),
    .fixed_oe(fx_oe), .periph_out(p_out), .pin_out(pin_out),
    .pin_oe(pin_oe), .remap_owned(own), .periph_in(p_in),
    .fixed_spi_clock_pin_out(fs_out), .fixed_spi_clock_pin_oe(fs_oe));
  prm_far_model far (.clock(clock), .new_pat(new_pat),
    .periph_out(p_out), .pin_in(pin_in));
  initial begin
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [63:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [63:0] got, exp);
    cmp(got, exp, "pin drive");
  endtask
  task automatic cmp_own(input logic [63:0] got, exp);
    cmp(got, exp, "owned");
  endtask
  task automatic cmp_in(input logic [63:0] got, exp);
    cmp(got, exp, "periph in");
  endtask
  task automatic cmp_alt(input logic [63:0] got, exp);
    cmp(got, exp, "alt pin");
  endtask
  task automatic cmp_rd(input logic [63:0] got, exp);
    cmp(got, exp, "readback");
  endtask
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [1:0] s, input int i, input int lo, hi);
    @(negedge clock);
    wr_en = 1;
    wr_sel = s;
    wr_index = 5'(i);
    wr_data = {2'h0, 6'(hi), 2'h0, 6'(lo)};
    @(negedge clock);
    wr_en = 0;
    if (s == PRM_WR_IN && i < PRM_IN_REGS) begin
      in_f[2*i] = lo;
      in_f[2*i+1] = hi;
    end
    if (s == PRM_WR_OUT && i < PRM_OUT_REGS) begin
      out_f[2*i] = lo;
      out_f[2*i+1] = hi;
    end
    if (s == PRM_WR_ALT) alt = lo & 1;
  endtask
  task automatic pulse();
    @(negedge clock);
    new_pat = 1;
    @(negedge clock);
    new_pat = 0;
  endtask
  task automatic chk();
    logic [31:0] eo, ee, ew;
    logic [41:0] ei;
    int c;
    repeat (8) @(negedge clock);
    for (int p = 0; p < 32; p++) begin
      c = out_f[p];
      ee[p] = 1;
      eo[p] = 0;
      ew[p] = 0;
      if (fx_oe[p]) eo[p] = fx_out[p];
      else if (c > 0 && c < 32 && !(c == 8 && alt == 1)) begin
        eo[p] = p_out[c];
        ew[p] = 1;
      end else if (pm_oe[p]) eo[p] = pm_out[p];
      else if (!dir[p]) eo[p] = port_out[p];
      else ee[p] = 0;
    end
    for (int i = 0; i < 42; i++) begin
      c = in_f[i];
      ei[i] = (c < 32) ? (pin_in[c] & !analog[c]) : 1'b0;
    end
    cmp_pin({pin_oe, pin_out & pin_oe}, {ee, eo});
    cmp_own(64'(own), 64'(ew));
    cmp_in(64'(p_in), 64'(ei));
    cmp_alt({alt_bit, fs_oe, fs_out & fs_oe},
      {alt[0], alt[0], alt[0] & p_out[8]});
  endtask
  task automatic rdback();
    logic [15:0] ei, eo;
    for (int r = 0; r < 23; r++) begin
      ei = 0;
      eo = 0;
      if (r < 21) ei = {2'h0, 6'(in_f[2*r+1]), 2'h0, 6'(in_f[2*r])};
      if (r < 16) eo = {2'h0, 6'(out_f[2*r+1]), 2'h0, 6'(out_f[2*r])};
      @(negedge clock);
      rd_index = 5'(r);
      repeat (3) @(negedge clock);
      cmp_rd({in_rd, out_rd}, {ei, eo});
    end
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'hFD0607FB));
    for (int i = 0; i < 42; i++) in_f[i] = 63;
    for (int i = 0; i < 32; i++) out_f[i] = 0;
    repeat (2) @(negedge clock);
    rstn = 1;
    pulse();
    chk();
    rdback();
    pm_oe = $urandom;
    pm_out = $urandom;
    dir = $urandom;
    port_out = $urandom;
    for (int r = 0; r < 17; r++) begin
      wr(PRM_WR_OUT, r, $urandom % 34, $urandom % 34);
    end
    pulse();
    chk();
    fx_oe = $urandom;
    fx_out = $urandom;
    chk();
    fx_oe = 0;
    dir = '1;
    for (int r = 0; r < 22; r++) begin
      wr(PRM_WR_IN, r, $urandom % 32, $urandom % 32);
    end
    pulse();
    chk();
    analog = $urandom;
    chk();
    wr(PRM_WR_OUT, 4, 8, 8);
    pulse();
    chk();
    wr(PRM_WR_ALT, 0, 1, 0);
    chk();
    wr(PRM_WR_ALT, 0, 0, 0);
    chk();
    rdback();
    final_report();
  end
endmodule
